// *** inc/falacg_pkg.sv ***
package falacg_pkg;
  // register subaddresses
  localparam logic [7:0] FALACG_CPF_LOW_ADDR = 8'h30;
  localparam logic [7:0] FALACG_CPF_MID_ADDR = 8'h31;
  localparam logic [7:0] FALACG_CPF_HIGH_ADDR = 8'h32;
  localparam logic [7:0] FALACG_INC_LOW_ADDR = 8'h34;
  localparam logic [7:0] FALACG_INC_MID_ADDR = 8'h35;
  localparam logic [7:0] FALACG_INC_HIGH_ADDR = 8'h36;
  localparam logic [7:0] FALACG_BIT_DIV_ADDR = 8'h38;
  localparam logic [7:0] FALACG_CHAN_DIV_ADDR = 8'h39;
  localparam logic [7:0] FALACG_EDGE_SEL_ADDR = 8'h3A;
  localparam logic [7:0] FALACG_LOOP_CTRL_ADDR = 8'h3B;
  localparam logic [7:0] FALACG_STATUS_ADDR = 8'h3C;
  // field positions
  localparam int FALACG_BIT_EDGE_POS = 0;
  localparam int FALACG_CHAN_EDGE_POS = 1;
  localparam int FALACG_LOOP_OPEN_POS = 0;
  localparam int FALACG_VREF_EXT_POS = 1;
  localparam int FALACG_STAT_XTAL_POS = 0;
  localparam int FALACG_STAT_LOCK_POS = 1;
  // widths
  localparam int FALACG_CPF_W = 18;
  localparam int FALACG_INC_W = 22;
  localparam int FALACG_ACC_W = 23;
  localparam int FALACG_CORR_W = 12;
  localparam int FALACG_CNT_W = 20;
  // reset values
  localparam logic [17:0] FALACG_CPF_RST = 18'h3C000;
  localparam logic [21:0] FALACG_INC_RST = 22'h30FBCE;
  localparam logic [5:0] FALACG_BIT_DIV_RST = 6'h03;
  localparam logic [5:0] FALACG_CHAN_DIV_RST = 6'h10;
  localparam logic [1:0] FALACG_EDGE_SEL_RST = 2'h0;
  localparam logic [1:0] FALACG_LOOP_CTRL_RST = 2'h0;
  // cycles after reset release before the strap is taken
  localparam logic [1:0] FALACG_STRAP_WAIT = 2'h3;
  // correction limits
  localparam logic signed [11:0] FALACG_CORR_MAX = 12'sh7FF;
  localparam logic signed [11:0] FALACG_CORR_MIN = -12'sh7FF;
endpackage

// *** rtl/falacg_divider.sv ***
`timescale 1ns/1ps
module falacg_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // source edge pulses
  input wire logic src_rise,
  input wire logic src_fall,
  // control
  input wire logic edge_sel,
  input wire logic add_one,
  input wire logic [5:0] divisor,
  // divided clock
  output logic clk_q,
  output logic rise_q,
  output logic fall_q
);
  logic [5:0] cnt_q;
  logic pick;
  logic run;
  logic wrap;
  logic [5:0] term;

  // edge 1 = rising source edge, 0 = falling (inverted source)
  assign pick = edge_sel ? src_rise : src_fall;
  assign term = add_one ? divisor : divisor - 6'h01;
  // a zero channel divisor holds the output
  assign run = add_one || (divisor != 6'h00);
  assign wrap = pick && run && (cnt_q >= term);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      clk_q <= 1'b0;
    end else if (pick && run) begin
      if (wrap) begin
        cnt_q <= 6'h00;
        clk_q <= ~clk_q;
      end else begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= wrap && !clk_q;
      fall_q <= wrap && clk_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_div_toggle_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(clk_q) |-> $past(pick) && $past(run))
    else $error("divided clock moved without a selected source edge");
  // a divisor lowered mid-count wraps at once, so the count may sit above term
  a_div_count_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(clk_q) |-> $past(cnt_q) >= $past(term))
    else $error("divided clock toggled at wrong count");
endmodule // falacg_divider

// *** rtl/falacg_top.sv ***
`timescale 1ns/1ps
module falacg_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // vertical references
  input wire logic internal_vsync,
  input wire logic external_vsync,
  // audio clock pins
  output logic audio_master_clock_out,
  input wire logic audio_master_clock_in,
  output logic audio_serial_bit_clock,
  output logic audio_channel_clock_o,
  output logic audio_channel_clock_oe,
  input wire logic audio_channel_clock_i,
  // crystal choice
  output logic xtal_select_q
);
  import falacg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [17:0] cpf_q;
  logic [21:0] inc_q;
  logic [5:0] bit_div_q;
  logic [5:0] chan_div_q;
  logic [1:0] edge_sel_q;
  logic [1:0] loop_ctrl_q;
  logic locked_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpf_q <= FALACG_CPF_RST;
      inc_q <= FALACG_INC_RST;
      bit_div_q <= FALACG_BIT_DIV_RST;
      chan_div_q <= FALACG_CHAN_DIV_RST;
      edge_sel_q <= FALACG_EDGE_SEL_RST;
      loop_ctrl_q <= FALACG_LOOP_CTRL_RST;
    end else if (reg_write) begin
      case (reg_addr)
        FALACG_CPF_LOW_ADDR: cpf_q[7:0] <= reg_wdata;
        FALACG_CPF_MID_ADDR: cpf_q[15:8] <= reg_wdata;
        FALACG_CPF_HIGH_ADDR: cpf_q[17:16] <= reg_wdata[1:0];
        FALACG_INC_LOW_ADDR: inc_q[7:0] <= reg_wdata;
        FALACG_INC_MID_ADDR: inc_q[15:8] <= reg_wdata;
        FALACG_INC_HIGH_ADDR: inc_q[21:16] <= reg_wdata[5:0];
        FALACG_BIT_DIV_ADDR: bit_div_q <= reg_wdata[5:0];
        FALACG_CHAN_DIV_ADDR: chan_div_q <= reg_wdata[5:0];
        FALACG_EDGE_SEL_ADDR: edge_sel_q <= reg_wdata[1:0];
        FALACG_LOOP_CTRL_ADDR: loop_ctrl_q <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // read data registered; unmapped subaddresses read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_read;
      if (reg_read) begin
        case (reg_addr)
          FALACG_CPF_LOW_ADDR: reg_rdata_q <= cpf_q[7:0];
          FALACG_CPF_MID_ADDR: reg_rdata_q <= cpf_q[15:8];
          FALACG_CPF_HIGH_ADDR: reg_rdata_q <= {6'h00, cpf_q[17:16]};
          FALACG_INC_LOW_ADDR: reg_rdata_q <= inc_q[7:0];
          FALACG_INC_MID_ADDR: reg_rdata_q <= inc_q[15:8];
          FALACG_INC_HIGH_ADDR: reg_rdata_q <= {2'h0, inc_q[21:16]};
          FALACG_BIT_DIV_ADDR: reg_rdata_q <= {2'h0, bit_div_q};
          FALACG_CHAN_DIV_ADDR: reg_rdata_q <= {2'h0, chan_div_q};
          FALACG_EDGE_SEL_ADDR: reg_rdata_q <= {6'h00, edge_sel_q};
          FALACG_LOOP_CTRL_ADDR: reg_rdata_q <= {6'h00, loop_ctrl_q};
          FALACG_STATUS_ADDR: reg_rdata_q <= {6'h00, locked_q, xtal_select_q};
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] mclk_sync_q;
  logic [2:0] vext_sync_q;
  logic [1:0] strap_sync_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_sync_q <= 3'h0;
      vext_sync_q <= 3'h0;
      strap_sync_q <= 2'h0;
    end else begin
      mclk_sync_q <= {mclk_sync_q[1:0], audio_master_clock_in};
      vext_sync_q <= {vext_sync_q[1:0], external_vsync};
      strap_sync_q <= {strap_sync_q[0], audio_channel_clock_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic [1:0] strap_cnt_q;
  logic strap_done_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      xtal_select_q <= 1'b0;
      audio_channel_clock_oe <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == FALACG_STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        xtal_select_q <= strap_sync_q[1];
        audio_channel_clock_oe <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field reference and master clock synthesis
  logic vref_q;
  logic field_edge;
  logic [FALACG_ACC_W-1:0] acc_q;
  logic [FALACG_ACC_W:0] acc_sum;
  logic signed [FALACG_CORR_W-1:0] corr_q;
  logic [FALACG_INC_W-1:0] inc_eff;
  logic [FALACG_CNT_W-1:0] mcnt_q;
  logic loop_open;

  assign loop_open = loop_ctrl_q[FALACG_LOOP_OPEN_POS];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vref_q <= 1'b0;
    end else begin
      vref_q <= loop_ctrl_q[FALACG_VREF_EXT_POS] ? vext_sync_q[1] : internal_vsync;
    end
  end

  assign field_edge = loop_ctrl_q[FALACG_VREF_EXT_POS] ? (vext_sync_q[1] && !vext_sync_q[2])
                                                        : (internal_vsync && !vref_q);
  assign inc_eff = inc_q + FALACG_INC_W'(corr_q);
  assign acc_sum = {1'b0, acc_q} + {2'h0, inc_eff};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      audio_master_clock_out <= 1'b0;
    end else begin
      acc_q <= acc_sum[FALACG_ACC_W-1:0];
      audio_master_clock_out <= acc_q[FALACG_ACC_W-1];
    end
  end

  // master periods in the current field
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcnt_q <= '0;
    end else if (field_edge) begin
      mcnt_q <= {19'h00000, acc_sum[FALACG_ACC_W]};
    end else if (acc_sum[FALACG_ACC_W] && !(&mcnt_q)) begin
      mcnt_q <= mcnt_q + 20'h00001;
    end
  end

  // slow loop: one correction step per field
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      corr_q <= '0;
      locked_q <= 1'b0;
    end else if (loop_open) begin
      corr_q <= '0;
      locked_q <= 1'b0;
    end else if (field_edge) begin
      locked_q <= (mcnt_q == {2'h0, cpf_q});
      if (mcnt_q < {2'h0, cpf_q} && corr_q != FALACG_CORR_MAX) begin
        corr_q <= corr_q + 12'sh001;
      end else if (mcnt_q > {2'h0, cpf_q} && corr_q != FALACG_CORR_MIN) begin
        corr_q <= corr_q - 12'sh001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial bit and channel clock division
  logic mclk_rise;
  logic mclk_fall;
  logic bit_rise;
  logic bit_fall;

  assign mclk_rise = mclk_sync_q[1] && !mclk_sync_q[2];
  assign mclk_fall = !mclk_sync_q[1] && mclk_sync_q[2];

  falacg_divider u_bit_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_rise(mclk_rise),
    .src_fall(mclk_fall),
    .edge_sel(edge_sel_q[FALACG_BIT_EDGE_POS]),
    .add_one(1'b1),
    .divisor(bit_div_q),
    .clk_q(audio_serial_bit_clock),
    .rise_q(bit_rise),
    .fall_q(bit_fall)
  );

  falacg_divider u_chan_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_rise(bit_rise),
    .src_fall(bit_fall),
    .edge_sel(edge_sel_q[FALACG_CHAN_EDGE_POS]),
    .add_one(1'b0),
    .divisor(chan_div_q),
    .clk_q(audio_channel_clock_o),
    .rise_q(),
    .fall_q()
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_open_loop_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
    loop_open |=> corr_q == 12'sh000 && inc_eff == inc_q)
    else $error("open loop still applies correction");
  a_loop_step_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
    field_edge && !loop_open && mcnt_q < {2'h0, cpf_q} && corr_q != FALACG_CORR_MAX
    |=> corr_q == $past(corr_q) + 12'sh001)
    else $error("short field did not raise correction");
  a_loop_step_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    field_edge && !loop_open && mcnt_q > {2'h0, cpf_q} && corr_q != FALACG_CORR_MIN
    |=> corr_q == $past(corr_q) - 12'sh001)
    else $error("long field did not lower correction");
  a_corr_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !field_edge && !loop_open |=> $stable(corr_q))
    else $error("correction moved between field edges");
  a_bit_edge_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(audio_serial_bit_clock) && edge_sel_q[FALACG_BIT_EDGE_POS]
    && $stable(edge_sel_q) |-> $past(mclk_rise))
    else $error("bit clock moved off the rising master edge");
  a_chan_edge_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(audio_channel_clock_o) && $stable(edge_sel_q) |->
    $past(edge_sel_q[FALACG_CHAN_EDGE_POS] ? bit_rise : bit_fall))
    else $error("channel clock moved off the selected bit edge");
  a_strap_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strap_done_q |=> strap_done_q && $stable(xtal_select_q) && audio_channel_clock_oe)
    else $error("crystal choice changed after capture");
  a_div_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_write && reg_addr == FALACG_BIT_DIV_ADDR |=> bit_div_q == $past(reg_wdata[5:0]))
    else $error("bit divisor write lost");
  a_master_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 audio_master_clock_out == $past(acc_q[FALACG_ACC_W-1]))
    else $error("master clock pin not from accumulator");

  c_locked_field: cover property (@(posedge ref_clk) disable iff (!rst_n)
    field_edge && !loop_open && mcnt_q == {2'h0, cpf_q});
  c_bit_toggle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(audio_serial_bit_clock));
  c_chan_toggle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(audio_channel_clock_o));
  c_open_loop: cover property (@(posedge ref_clk) disable iff (!rst_n)
    loop_open && field_edge);
endmodule // falacg_top

// *** bench/falacg_codec_model.sv ***
`timescale 1ns/1ps
// far-side converter and board: loop-back and strap resistor
module falacg_codec_model (
  // from device
  input wire logic audio_master_clock_out,
  input wire logic audio_channel_clock_o,
  input wire logic audio_channel_clock_oe,
  // board strap level
  input wire logic strap_level,
  // to device
  output logic audio_master_clock_in,
  output logic audio_channel_clock_i
);
  // standard board: master output shorted to divider input
  assign audio_master_clock_in = audio_master_clock_out;
  // strap resistor sets the pin whenever the device does not drive it
  assign audio_channel_clock_i = audio_channel_clock_oe ? audio_channel_clock_o :
    strap_level;
endmodule // falacg_codec_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import falacg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic internal_vsync = 1'b0;
  logic external_vsync = 1'b0;
  logic mclk_out, mclk_in, sclk, lr_o, lr_oe, lr_i, xtal_select_q;
  logic strap = 1'b0;
  logic vs_int_en = 1'b0;
  logic vs_ext_en = 1'b0;
  int vs_cnt = 0;
  int miscompares = 0;
  int samples_checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////
  falacg_top u_falacg_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .internal_vsync(internal_vsync),
    .external_vsync(external_vsync), .audio_master_clock_out(mclk_out),
    .audio_master_clock_in(mclk_in), .audio_serial_bit_clock(sclk),
    .audio_channel_clock_o(lr_o), .audio_channel_clock_oe(lr_oe),
    .audio_channel_clock_i(lr_i), .xtal_select_q(xtal_select_q)
  );
  falacg_codec_model u_falacg_codec_model (
    .audio_master_clock_out(mclk_out), .audio_channel_clock_o(lr_o),
    .audio_channel_clock_oe(lr_oe), .strap_level(strap),
    .audio_master_clock_in(mclk_in), .audio_channel_clock_i(lr_i)
  );

  // field of 1600 cycles = 100 master periods of 16 cycles
  always @(posedge ref_clk) begin
    vs_cnt <= (vs_cnt == 1599) ? 0 : vs_cnt + 1;
    internal_vsync <= #1 vs_int_en && vs_cnt < 100;
    external_vsync <= #1 vs_ext_en && vs_cnt < 100;
  end

  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    tick(1);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    reg_addr = a;
    reg_read = 1'b1;
    tick(1);
    reg_read = 1'b0;
    n = 0;
    while (reg_rvalid_q !== 1'b1 && n < 3) begin
      tick(1);
      n++;
    end
    chk_num(n < 3, 1, "read answer");
    d = reg_rdata_q;
    tick(1);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return mclk_in;
      1: return sclk;
      2: return lr_o;
      default: return mclk_out;
    endcase
  endfunction

  task automatic wait_chg(input int w, input int lim, output int n);
    logic p;
    p = sig(w);
    n = 0;
    while (sig(w) === p && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic period(input int w, input int exp);
    int a, b;
    wait_chg(w, 5000, a);
    wait_chg(w, 5000, a);
    wait_chg(w, 5000, b);
    chk_num(a + b, exp, "clock period");
  endtask

  // level of the source clock each time the divided clock moves
  task automatic edge_rel(input int w, input int src, input logic lvl);
    int n;
    repeat (4) begin
      wait_chg(w, 5000, n);
      chk_num(sig(src), lvl, "trigger edge");
    end
  endtask

  task automatic do_reset(input logic lvl);
    rst_n = 1'b0;
    strap = lvl;
    tick(6);
    chk_num({mclk_out, sclk, lr_oe}, 0, "outputs in reset");
    rst_n = 1'b1;
    tick(8);
    chk_num(xtal_select_q, lvl, "crystal choice");
    chk_num(lr_oe, 1, "channel pin drive");
  endtask

  task automatic lock_seen(output logic s);
    logic [7:0] d;
    s = 1'b0;
    repeat (24) begin
      tick(400);
      reg_rd(8'h3C, d);
      s = s | d[1];
    end
  endtask

  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ad [12] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36,
      8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h33};
    logic [7:0] ex [12] = '{8'h00, 8'hC0, 8'h03, 8'hCE, 8'hFB, 8'h30,
      8'h03, 8'h10, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] mk [12] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F,
      8'h3F, 8'h3F, 8'h03, 8'h03, 8'h01, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 12; i++) begin
      reg_rd(ad[i], d);
      chk_byte(d, ex[i], "reset value");
    end
    for (int i = 0; i < 12; i++) begin
      reg_wr(ad[i], 8'hFF);
      reg_rd(ad[i], d);
      chk_byte(d, mk[i], "readback");
    end
  endtask

  task automatic t_clocks();
    logic [7:0] dv [3] = '{8'h00, 8'h01, 8'h03};
    int n;
    // increment 2^19 of 2^23: master period 16 cycles, loop open
    reg_wr(8'h34, 8'h00);
    reg_wr(8'h35, 8'h00);
    reg_wr(8'h36, 8'h08);
    reg_wr(8'h3B, 8'h01);
    period(3, 16);
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 2; s++) begin
        reg_wr(8'h38, dv[i]);
        reg_wr(8'h3A, {7'h00, s[0]});
        period(1, 32 * (dv[i] + 1));
        edge_rel(1, 0, s[0]);
      end
    end
    reg_wr(8'h38, 8'h00);
    for (int c = 1; c < 3; c++) begin
      for (int s = 0; s < 2; s++) begin
        reg_wr(8'h39, c[7:0]);
        reg_wr(8'h3A, {6'h00, s[0], 1'b1});
        period(2, 64 * c);
        edge_rel(2, 1, s[0]);
      end
    end
    reg_wr(8'h39, 8'h00);
    tick(200);
    wait_chg(2, 400, n);
    chk_num(n, 400, "channel clock held");
  endtask

  task automatic t_loop();
    logic s;
    logic [7:0] d;
    reg_wr(8'h3A, 8'h00);
    reg_wr(8'h30, 8'hC8);
    reg_wr(8'h31, 8'h00);
    reg_wr(8'h32, 8'h00);
    vs_int_en = 1'b1;
    reg_wr(8'h3B, 8'h00);
    lock_seen(s);
    chk_num(s, 0, "lock on wrong count");
    reg_wr(8'h3B, 8'h02);
    reg_wr(8'h30, 8'h64);
    lock_seen(s);
    chk_num(s, 0, "lock from unselected field");
    reg_wr(8'h3B, 8'h00);
    lock_seen(s);
    chk_num(s, 1, "lock on internal field");
    reg_wr(8'h30, 8'hC8);
    tick(4800);
    vs_int_en = 1'b0;
    vs_ext_en = 1'b1;
    reg_wr(8'h3B, 8'h02);
    reg_wr(8'h30, 8'h64);
    lock_seen(s);
    chk_num(s, 1, "lock on external field");
    reg_wr(8'h3B, 8'h01);
    reg_rd(8'h3C, d);
    chk_byte(d, 8'h01, "open loop status");
  endtask

  ////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    t_regs();
    t_clocks();
    t_loop();
    test_done();
  end

  initial begin
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
endmodule // tb_top
